// File: src/wit_watch_timer.sv
// watch timer and interval timer with its mode register
// Function
// R1 - 11-bit prescaler on the watch clock feeds a 5-bit counter.
// R2 - watch clock is main oscillator/128 when select is 0, subsystem oscillator when 1.
// R3 - 3-bit field picks interval of 2^4 to 2^11 watch clock periods.
// R4 - interval interrupt repeats every selected period while enable is set.
// R5 - 2-bit field picks watch period 2^14, 2^13, 2^5 or 2^4.
// R6 - enable 0 stops and clears prescaler and counter.
// R7 - counter counts only with enable and run both set, else cleared.
// R8 - clearing run alone resets counter but keeps prescaler running.
// R9 - interval timer follows enable only, not the run bit.
// R10 - first watch interrupt delayed one prescaler output cycle, later ones exact; code delays it one watch clock cycle for 2^5 and 2^4 periods.
// R11 - mode register resets to zero, takes bit and byte writes, is readable.
// R12 - software keeps clock select and interval field stable while running.
// R13 - each interrupt is a one-cycle pulse in the system clock domain.
`timescale 1ns/100ps
`include "wit_cfg.svh"
module wit_watch_timer #(
  parameter int PRESC_W = `WIT_PRESC_W,
  parameter int CNT_W = `WIT_CNT_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // oscillator sources
  input wire logic main_osc_tick,
  input wire logic sub_osc_lvl,
  // cpu register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_en,
  input wire wit_pkg::wit_byte_t reg_wr_data,
  input wire logic reg_bit_wr,
  input wire logic [2:0] reg_bit_sel,
  input wire logic reg_bit_val,
  input wire logic reg_rd_en,
  output wit_pkg::wit_byte_t reg_rd_data,
  // interrupt requests
  output logic watch_irq,
  output logic interval_irq
);
  import wit_pkg::*;

  if (PRESC_W != `WIT_PRESC_W || CNT_W != `WIT_CNT_W) begin : g_chk
    $error("wit_watch_timer: prescaler must be 11 bits and counter 5 bits");
  end

  wit_byte_t watch_mode_reg_q;
  wit_byte_t watch_mode_reg_d;
  wit_byte_t rd_data_q;
  logic [PRESC_W-1:0] presc_q;
  logic [CNT_W-1:0] cnt_q;
  wit_cnt_state_t cnt_state_q;
  logic watch_irq_q;
  logic interval_irq_q;
  logic watch_tick;
  logic watch_enable;
  logic subcounter_run;
  logic count_clock_select;
  logic [1:0] alarm_period_sel;
  logic [2:0] interval_sel;
  logic run_ok;
  logic fwx_pulse;
  logic ivl_hit;
  logic cnt_inc;
  logic cnt_wrap;
  logic reg_hit;

  // true when the low n bits of the prescaler are all ones
  function automatic logic low_ones(input logic [PRESC_W-1:0] p, input int n);
    logic r;
    r = 1'b1;
    for (int i = 0; i < PRESC_W; i++) begin
      if (i < n && !p[i]) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction

  // mode register fields
  assign watch_enable = watch_mode_reg_q[`WIT_BIT_ENABLE];
  assign subcounter_run = watch_mode_reg_q[`WIT_BIT_RUN];
  assign alarm_period_sel = watch_mode_reg_q[`WIT_BIT_ALARM_HI:`WIT_BIT_ALARM_LO];
  assign interval_sel = watch_mode_reg_q[`WIT_BIT_IVL_HI:`WIT_BIT_IVL_LO];
  assign count_clock_select = watch_mode_reg_q[`WIT_BIT_CLK_SEL];
  assign reg_hit = (reg_addr == `WIT_MODE_ADDR);

  // watch clock source, rising as one-cycle ticks
  wit_clk_sel i_wit_clk_sel (
    .clk_sys(clk_sys),
    .srst(srst),
    .main_osc_tick(main_osc_tick),
    .sub_osc_lvl(sub_osc_lvl),
    .use_sub(count_clock_select),
    .watch_tick_q(watch_tick)
  );

  // next mode value from a byte write or a single-bit write
  always_comb begin
    watch_mode_reg_d = watch_mode_reg_q;
    if (reg_hit && reg_wr_en) begin
      watch_mode_reg_d = reg_wr_data; // [R11]
    end else if (reg_hit && reg_bit_wr) begin
      watch_mode_reg_d[reg_bit_sel] = reg_bit_val; // [R11]
    end
  end

  // mode register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      watch_mode_reg_q <= `WIT_MODE_RST; // [R11]
    end else begin
      watch_mode_reg_q <= watch_mode_reg_d;
    end
  end

  // registered read data, zero for other addresses
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_data_q <= `WIT_MODE_RST;
    end else if (reg_rd_en && reg_hit) begin
      rd_data_q <= watch_mode_reg_q; // [R11]
    end else begin
      rd_data_q <= '0;
    end
  end

  // 11-bit prescaler, held at zero while disabled
  always_ff @(posedge clk_sys) begin
    if (srst || !watch_enable) begin
      presc_q <= '0; // [R6]
    end else if (watch_tick) begin
      presc_q <= presc_q + 1'b1; // [R1] [R8]
    end
  end

  // counter clock: watch clock itself for short periods, prescaler 2^9 output otherwise
  assign fwx_pulse = watch_tick && watch_enable &&
    (alarm_period_sel[1] || low_ones(presc_q, `WIT_FWX_TAP)); // [R1] [R5]
  assign ivl_hit = watch_tick && watch_enable &&
    low_ones(presc_q, `WIT_IVL_BASE + int'(interval_sel)); // [R3] [R9]
  assign run_ok = watch_enable && subcounter_run; // [R7]
  assign cnt_inc = fwx_pulse && (cnt_state_q == WIT_CS_RUN);
  assign cnt_wrap = alarm_period_sel[0] ? (cnt_q[3:0] == 4'(`WIT_ALARM_SHORT_LAST)) :
    (cnt_q == `WIT_ALARM_LONG_LAST); // [R5]

  // start sequence: first counter clock only arms the counter
  always_ff @(posedge clk_sys) begin
    if (srst || !run_ok) begin
      cnt_state_q <= WIT_CS_IDLE; // [R7]
    end else begin
      case (cnt_state_q)
        WIT_CS_IDLE: cnt_state_q <= WIT_CS_ARM;
        WIT_CS_ARM: begin
          if (fwx_pulse) begin
            cnt_state_q <= WIT_CS_RUN; // [R10]
          end
        end
        WIT_CS_RUN: cnt_state_q <= WIT_CS_RUN;
        default: cnt_state_q <= WIT_CS_IDLE;
      endcase
    end
  end

  // 5-bit counter, cleared whenever enable or run is low
  always_ff @(posedge clk_sys) begin
    if (srst || !run_ok) begin
      cnt_q <= '0; // [R6] [R7] [R8]
    end else if (cnt_inc) begin
      cnt_q <= cnt_q + 1'b1; // [R1]
    end
  end

  // one-cycle interrupt pulses
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      watch_irq_q <= 1'b0;
      interval_irq_q <= 1'b0;
    end else begin
      watch_irq_q <= cnt_inc && cnt_wrap; // [R5] [R13]
      interval_irq_q <= ivl_hit; // [R4] [R13]
    end
  end

  assign watch_irq = watch_irq_q;
  assign interval_irq = interval_irq_q;
  assign reg_rd_data = rd_data_q;

  // checks
  a_reset_mode_clear: assert property (@(posedge clk_sys) $past(srst) && !srst |-> watch_mode_reg_q == 8'h00) // [R11]
    else $error("mode register not zero after reset");
  a_byte_write_store: assert property (@(posedge clk_sys) disable iff (srst)
    reg_wr_en && reg_hit |=> watch_mode_reg_q == $past(reg_wr_data)) // [R11]
    else $error("byte write not stored");
  a_disable_clears: assert property (@(posedge clk_sys) disable iff (srst)
    !watch_enable |=> presc_q == '0 && cnt_q == '0 && !interval_irq) // [R6]
    else $error("disabled timer not cleared");
  a_run_clear_cnt: assert property (@(posedge clk_sys) disable iff (srst)
    !subcounter_run && watch_enable && watch_tick |=> cnt_q == '0 && presc_q == $past(presc_q) + 1'b1) // [R8]
    else $error("run clear wrong");
  a_presc_step: assert property (@(posedge clk_sys) disable iff (srst)
    watch_enable && watch_tick ##1 watch_enable |-> presc_q == $past(presc_q) + 1'b1) // [R1]
    else $error("prescaler did not step");
  a_irq_single_pulse: assert property (@(posedge clk_sys) disable iff (srst)
    watch_irq_q |=> !watch_irq_q) // [R13]
    else $error("watch interrupt longer than one cycle");
  a_ivl_single_pulse: assert property (@(posedge clk_sys) disable iff (srst)
    interval_irq_q |=> !interval_irq_q) // [R13]
    else $error("interval interrupt longer than one cycle");
  a_interval_cause: assert property (@(posedge clk_sys) disable iff (srst)
    interval_irq_q |-> $past(watch_tick) && $past(watch_enable) &&
    $past(low_ones(presc_q, `WIT_IVL_BASE + int'(interval_sel)))) // [R3] [R4]
    else $error("interval interrupt without tap");
  a_watch_cause: assert property (@(posedge clk_sys) disable iff (srst)
    watch_irq_q |-> $past(run_ok) && $past(cnt_wrap) && $past(cnt_state_q) == WIT_CS_RUN) // [R5] [R7]
    else $error("watch interrupt without counter wrap");
  a_first_arm: assert property (@(posedge clk_sys) disable iff (srst)
    cnt_state_q == WIT_CS_ARM && fwx_pulse && run_ok |=> cnt_q == '0 && cnt_state_q == WIT_CS_RUN) // [R10]
    else $error("first counter clock was counted");
endmodule

// File: shared/wit_cfg.svh
// register address, field positions, reset values and divider counts of the watch and interval timer
`ifndef WIT_CFG_SVH
`define WIT_CFG_SVH

`define WIT_MODE_ADDR 16'hFF6F
`define WIT_MODE_RST 8'h00
`define WIT_BIT_ENABLE 0
`define WIT_BIT_RUN 1
`define WIT_BIT_ALARM_LO 2
`define WIT_BIT_ALARM_HI 3
`define WIT_BIT_IVL_LO 4
`define WIT_BIT_IVL_HI 6
`define WIT_BIT_CLK_SEL 7
`define WIT_MAIN_DIV_W 7
`define WIT_MAIN_DIV_LAST 7'h7F
`define WIT_PRESC_W 11
`define WIT_CNT_W 5
`define WIT_FWX_TAP 9
`define WIT_IVL_BASE 4
`define WIT_ALARM_SHORT_LAST 5'h0F
`define WIT_ALARM_LONG_LAST 5'h1F
`define WIT_CLK_PERIOD_NS 40

`endif

// File: shared/wit_pkg.sv
// types of the watch and interval timer
package wit_pkg;

  // start sequence of the 5-bit counter, one-hot
  typedef enum logic [2:0] {
    WIT_CS_IDLE = 3'b001,
    WIT_CS_ARM  = 3'b010,
    WIT_CS_RUN  = 3'b100
  } wit_cnt_state_t;

  typedef logic [7:0] wit_byte_t;

endpackage

// File: src/wit_clk_sel.sv
// watch clock tick generator: main oscillator divided by 128 or subsystem oscillator edge
`timescale 1ns/100ps
`include "wit_cfg.svh"
module wit_clk_sel (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // oscillator sources
  input wire logic main_osc_tick,
  input wire logic sub_osc_lvl,
  // selection and result
  input wire logic use_sub,
  output logic watch_tick_q
);
  logic [`WIT_MAIN_DIV_W-1:0] div_q;
  logic sub_lvl_q;

  // free running divide-by-128 of main oscillator ticks
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_q <= '0;
    end else if (main_osc_tick) begin
      div_q <= div_q + 1'b1;
    end
  end

  // previous subsystem level for rising edge detection
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sub_lvl_q <= 1'b0;
    end else begin
      sub_lvl_q <= sub_osc_lvl;
    end
  end

  // one-cycle watch clock tick from the selected source
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      watch_tick_q <= 1'b0;
    end else if (use_sub) begin
      watch_tick_q <= sub_osc_lvl & ~sub_lvl_q; // [R2]
    end else begin
      watch_tick_q <= main_osc_tick && (div_q == `WIT_MAIN_DIV_LAST); // [R2]
    end
  end
endmodule

// File: sim/tb_watch_and_interval_timer.sv
// self-checking bench of the watch and interval timer
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_watch_and_interval_timer;
  import wit_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic osc = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr_en = 1'b0;
  wit_byte_t reg_wr_data = 8'h00;
  logic reg_bit_wr = 1'b0;
  logic [2:0] reg_bit_sel = 3'h0;
  logic reg_bit_val = 1'b0;
  logic reg_rd_en = 1'b0;
  wit_byte_t reg_rd_data, rdat;
  logic watch_irq, interval_irq;
  int fails = 0, tests_run = 0, wcnt = 0, icnt = 0, n, c0;
  // rows: write address, write data, read address, expected read
  logic [47:0] rows [5] = '{{16'hFF6F, 8'h80, 16'hFF6F, 8'h80}, {16'hFF6E, 8'hFF, 16'hFF6F, 8'h80},
    {16'hFF6F, 8'h5A, 16'hFF70, 8'h00}, {16'hFF6F, 8'hA4, 16'hFF6F, 8'hA4}, {16'hFF6F, 8'h00, 16'hFF6F, 8'h00}};

  wit_watch_timer i_wit_watch_timer (.clk_sys(clk_sys), .srst(srst), .main_osc_tick(osc), .sub_osc_lvl(osc),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_bit_wr(reg_bit_wr),
    .reg_bit_sel(reg_bit_sel), .reg_bit_val(reg_bit_val), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .watch_irq(watch_irq), .interval_irq(interval_irq));

  // clock, and one oscillator edge every two cycles for both sources
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) osc <= ~osc;
  // count interrupt pulses
  always @(posedge clk_sys) begin
    if (watch_irq === 1'b1) wcnt <= wcnt + 1;
    if (interval_irq === 1'b1) icnt <= icnt + 1;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // byte write, bit write and read of the mode register
  task automatic wr(input logic [15:0] a, input wit_byte_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
  endtask
  task automatic bw(input logic [2:0] b, input logic v);
    @(posedge clk_sys);
    reg_addr <= 16'hFF6F;
    reg_bit_sel <= b;
    reg_bit_val <= v;
    reg_bit_wr <= 1'b1;
    @(posedge clk_sys);
    reg_bit_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output wit_byte_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1 d = reg_rd_data;
  endtask
  // cycles until the chosen interrupt pulses, then it must drop
  task automatic wait_irq(input bit w, input int lim, output int k);
    k = 0;
    do begin
      @(posedge clk_sys);
      #1 k++;
    end while ((w ? watch_irq : interval_irq) !== 1'b1 && k < lim);
    `CHK(k < lim, 1'b1)
    @(posedge clk_sys);
    #1 `CHK(w ? watch_irq : interval_irq, 1'b0)
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    rd(16'hFF6F, rdat);
    `CHK(rdat, 8'h00)
    `CHK({watch_irq, interval_irq}, 2'b00)
    foreach (rows[i]) begin
      wr(rows[i][47:32], rows[i][31:24]);
      rd(rows[i][23:8], rdat);
      `CHK(rdat, rows[i][7:0])
    end
    bw(3'h7, 1'b1);
    bw(3'h2, 1'b1);
    rd(16'hFF6F, rdat);
    `CHK(rdat, 8'h84)
    wr(16'hFF6F, 8'h00);
    $display("register tests done");
    // interval codes, stopping before each change of the field
    for (int s = 0; s < 8; s++) begin
      wr(16'hFF6F, {1'b1, 3'(s), 4'h1});
      wait_irq(0, 5000, n);
      wait_irq(0, 5000, n);
      `CHK(n, (2 << (4 + s)) - 1)
      wr(16'hFF6F, 8'h00);
    end
    wr(16'hFF6F, 8'h01);
    wait_irq(0, 9000, n);
    wait_irq(0, 9000, n);
    `CHK(n, 4095)
    wr(16'hFF6F, 8'h00);
    $display("interval tests done");
    // stopped timer stays silent and restarts from a cleared prescaler
    c0 = wcnt + icnt;
    repeat (300) @(posedge clk_sys);
    `CHK(wcnt + icnt, c0)
    wr(16'hFF6F, 8'h81);
    wait_irq(0, 100, n);
    `CHK(n >= 28 && n <= 38, 1'b1)
    wr(16'hFF6F, 8'h00);
    $display("stop and restart tests done");
    // short watch periods
    for (int a = 2; a < 4; a++) begin
      wr(16'hFF6F, {4'h8, 2'(a), 2'h3});
      wait_irq(1, 200, n);
      wait_irq(1, 200, n);
      `CHK(n, (a == 2) ? 63 : 31)
    end
    // clearing run alone stops the watch but not the interval
    bw(3'h1, 1'b0);
    // a pulse launched on the edge that cleared run is counted one edge later
    repeat (2) @(posedge clk_sys);
    c0 = wcnt;
    n = icnt;
    repeat (200) @(posedge clk_sys);
    `CHK(wcnt, c0)
    `CHK(icnt - n >= 5, 1'b1)
    $display("short watch tests done");
    // long periods: first pulse one prescaler output cycle late
    for (int a = 1; a >= 0; a--) begin
      wr(16'hFF6F, 8'h00);
      wr(16'hFF6F, {4'h8, 2'(a), 2'h3});
      wait_irq(1, 40000, n);
      c0 = 2 * ((1 << (14 - a)) + 512);
      `CHK(n >= c0 - 4 && n <= c0 + 6, 1'b1)
    end
    $display("long watch tests done");
    // reset in mid-run clears the mode register and silences both requests
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rd(16'hFF6F, rdat);
    `CHK(rdat, 8'h00)
    c0 = wcnt + icnt;
    repeat (100) @(posedge clk_sys);
    `CHK(wcnt + icnt, c0)
    $display("reset tests done");
    tally_and_finish();
  end

  // watchdog on the whole run: the scenarios need about 77000 cycles
  initial begin
    repeat (95000) @(posedge clk_sys);
    fails++;
    tally_and_finish();
  end
endmodule
